// file: addr_gen_pkg.sv
// constants and types shared by the circular address generator
package addr_gen_pkg;

  // per-register mode field encodings
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_LINEAR = 2'h0;
  localparam logic [1:0] MODE_CIRC_FIRST = 2'h1;
  localparam logic [1:0] MODE_CIRC_SECOND = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // address mode register layout
  localparam int MODE_FIELDS_PER_SIDE = 4;
  localparam int BLOCK_W = 5;
  localparam int BLOCK_FIRST_POS = 16;
  localparam int BLOCK_SECOND_POS = 21;

  // register numbers with special roles
  localparam logic [4:0] CIRC_REG_LO = 5'h04;
  localparam logic [4:0] CIRC_REG_HI = 5'h07;
  localparam logic [4:0] LONG_BASE_FIRST = 5'h0e;
  localparam logic [4:0] LONG_BASE_SECOND = 5'h0f;

  // offset scaling shifts per access size
  localparam logic [1:0] SHIFT_BYTE = 2'h0;
  localparam logic [1:0] SHIFT_HALF = 2'h1;
  localparam logic [1:0] SHIFT_WORD = 2'h2;
  localparam logic [1:0] SHIFT_DOUBLE = 2'h3;

  // reset value of every data output
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [4:0] RESET_REG = 5'h00;

  // element count used by the bare increment and decrement forms
  localparam logic [31:0] UNIT_STEP = 32'h0000_0001;

  typedef enum logic [2:0] {
    OP_OTHER = 3'h0,
    OP_LOAD = 3'h1,
    OP_STORE = 3'h2,
    OP_SCALED_ADD = 3'h3,
    OP_SCALED_SUB = 3'h4
  } op_e;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2,
    SIZE_DOUBLE = 2'h3
  } size_e;

  typedef enum logic [1:0] {
    OFF_NONE = 2'h0,
    OFF_CONST_FIVE = 2'h1,
    OFF_INDEX = 2'h2,
    OFF_CONST_FIFTEEN = 2'h3
  } offset_src_e;

  typedef enum logic [1:0] {
    MOD_NONE = 2'h0,
    MOD_PRE = 2'h1,
    MOD_POST = 2'h2
  } modify_e;

endpackage

// file: circular_address_generator.sv
// effective address datapath for one data-path address unit, linear and circular
module circular_address_generator
  import addr_gen_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // issued operation
  input wire logic i_valid,
  input wire op_e i_op,
  input wire size_e i_size,
  input wire logic i_subtract,
  input wire offset_src_e i_offset_src,
  input wire modify_e i_modify,
  input wire logic i_unit_side_b,
  // operands from decode and register file
  input wire logic [4:0] i_base_reg_idx,
  input wire logic [31:0] i_base_register_operand,
  input wire logic [31:0] i_index_register_operand,
  input wire logic [4:0] i_unsigned_const_five,
  input wire logic [14:0] i_unsigned_const_fifteen,
  // control state
  input wire logic [31:0] i_address_mode_register,
  // memory access stage
  output logic o_mem_req,
  output logic o_mem_write,
  output logic [31:0] o_mem_address,
  // register write back
  output logic o_wb_en,
  output logic o_wb_side_b,
  output logic [4:0] o_wb_reg_idx,
  output logic [31:0] o_wb_value,
  // status
  output logic o_done,
  output logic o_form_error,
  output logic o_reserved_mode
);

  // scale an operand by the access size
  function automatic logic [31:0] scale(input logic [31:0] v, input size_e sz);
    logic [1:0] sh;
    sh = SHIFT_BYTE;
    unique case (sz)
      SIZE_BYTE: sh = SHIFT_BYTE;
      SIZE_HALF: sh = SHIFT_HALF;
      SIZE_WORD: sh = SHIFT_WORD;
      SIZE_DOUBLE: sh = SHIFT_DOUBLE;
    endcase
    return v << sh;
  endfunction

  // add or subtract with carry cut above the masked low bits
  function automatic logic [31:0] masked_sum(input logic [31:0] base,
                                             input logic [31:0] off,
                                             input logic sub,
                                             input logic [31:0] mask);
    logic [31:0] raw;
    raw = sub ? (base - off) : (base + off);
    return (base & ~mask) | (raw & mask);
  endfunction

  // circular capable registers are 4-7 of the unit's own side
  function automatic logic circ_capable(input logic [4:0] idx);
    return (idx >= CIRC_REG_LO) && (idx <= CIRC_REG_HI);
  endfunction

  // two-bit mode field of a register; side A fields sit below side B fields
  function automatic logic [1:0] mode_field(input logic [31:0] address_mode_register,
                                            input logic side_b,
                                            input logic [4:0] idx);
    logic [31:0] shifted;
    shifted = address_mode_register >> {side_b, idx[1:0], 1'h0};
    return shifted[MODE_W-1:0];
  endfunction

  // ones in bits 0..n; block size is bytes, never scaled by access size
  function automatic logic [31:0] low_mask(input logic [BLOCK_W-1:0] n);
    logic [4:0] sh;
    sh = 5'h1f - n;
    return 32'hffff_ffff >> sh;
  endfunction

  // registered outputs
  logic mem_req_q;
  logic mem_write_q;
  logic wb_en_q;
  logic done_q;
  logic form_error_q;
  logic reserved_mode_q;
  logic [31:0] mem_address_q;
  logic [31:0] wb_value_q;
  logic [4:0] wb_reg_idx_q;
  logic wb_side_b_q;

  // operation class decode
  wire logic is_ldst;
  wire logic is_scaled;
  wire logic uses_modes;
  wire logic op_sub;
  assign is_ldst = (i_op == OP_LOAD) || (i_op == OP_STORE);
  assign is_scaled = (i_op == OP_SCALED_ADD) || (i_op == OP_SCALED_SUB);
  assign uses_modes = is_ldst || is_scaled;
  assign op_sub = is_scaled ? (i_op == OP_SCALED_SUB) : i_subtract;

  // modification decode; the spare code modifies nothing
  wire logic pre_form;
  wire logic post_form;
  wire logic modifies;
  assign pre_form = (i_modify == MOD_PRE);
  assign post_form = (i_modify == MOD_POST);
  assign modifies = pre_form || post_form;

  // address register always sits on the unit's own side
  wire logic circ_reg;
  wire logic circ_eligible;
  wire logic [1:0] reg_mode;
  assign circ_reg = circ_capable(i_base_reg_idx);
  assign circ_eligible = uses_modes && circ_reg;
  assign reg_mode =
    mode_field(i_address_mode_register, i_unit_side_b, i_base_reg_idx);

  wire logic mode_first;
  wire logic mode_second;
  wire logic mode_resv;
  wire logic circular;
  assign mode_first = (reg_mode == MODE_CIRC_FIRST);
  assign mode_second = (reg_mode == MODE_CIRC_SECOND);
  // reserved code falls back to linear so the address stays defined
  assign mode_resv = circ_eligible && (reg_mode == MODE_RESERVED);
  assign circular = circ_eligible && (mode_first || mode_second);

  // block size field picked by the mode
  wire logic [BLOCK_W-1:0] block_first;
  wire logic [BLOCK_W-1:0] block_second;
  wire logic [BLOCK_W-1:0] block_n;
  assign block_first = i_address_mode_register[BLOCK_FIRST_POS +: BLOCK_W];
  assign block_second = i_address_mode_register[BLOCK_SECOND_POS +: BLOCK_W];
  assign block_n = mode_second ? block_second : block_first;

  // an all-ones mask turns the same adder into a plain linear one
  wire logic [31:0] circ_mask;
  wire logic [31:0] lin_mask;
  wire logic [31:0] sum_mask;
  assign circ_mask = low_mask(block_n);
  assign lin_mask = 32'hffff_ffff;
  assign sum_mask = circular ? circ_mask : lin_mask;

  // raw offset operand; bare step forms move by one element
  logic [31:0] raw_offset;
  always_comb begin
    raw_offset = RESET_WORD;
    unique case (i_offset_src)
      OFF_NONE: raw_offset = modifies ? UNIT_STEP : RESET_WORD;
      OFF_CONST_FIVE: raw_offset = {27'h0, i_unsigned_const_five};
      OFF_INDEX: raw_offset = i_index_register_operand;
      OFF_CONST_FIFTEEN: raw_offset = {17'h0, i_unsigned_const_fifteen};
    endcase
  end

  // scaled offset, or scaled first source of a scaled add/sub
  wire logic [31:0] scaled_offset;
  wire logic [31:0] new_address;
  assign scaled_offset = scale(raw_offset, i_size);
  // masking the sum drops any part of the offset beyond the buffer
  assign new_address =
    masked_sum(i_base_register_operand, scaled_offset, op_sub, sum_mask);

  // long-offset form checks
  wire logic long_form;
  wire logic long_base;
  wire logic long_bad;
  wire logic scaled_bad;
  wire logic form_bad;
  assign long_form = is_ldst && (i_offset_src == OFF_CONST_FIFTEEN);
  assign long_base = i_unit_side_b &&
    ((i_base_reg_idx == LONG_BASE_FIRST) || (i_base_reg_idx == LONG_BASE_SECOND));
  assign long_bad = long_form && (!long_base || (i_modify != MOD_NONE));
  // scaled ops only accept register or 5-bit constant first sources
  assign scaled_bad = is_scaled &&
    ((i_offset_src == OFF_NONE) || (i_offset_src == OFF_CONST_FIFTEEN));
  assign form_bad = long_bad || scaled_bad;

  // access address: post forms use the untouched base
  wire logic [31:0] access_address;
  assign access_address = post_form ? i_base_register_operand : new_address;

  // next values of the pulse outputs
  wire logic take;
  wire logic ldst_wb;
  wire logic mem_req_d;
  wire logic mem_write_d;
  wire logic wb_en_d;
  wire logic done_d;
  wire logic form_error_d;
  wire logic reserved_mode_d;
  assign take = i_valid && !form_bad;
  assign ldst_wb = is_ldst && modifies;
  assign mem_req_d = take && is_ldst;
  assign mem_write_d = take && (i_op == OP_STORE);
  assign wb_en_d = take && (ldst_wb || is_scaled);
  assign done_d = i_valid;
  assign form_error_d = i_valid && form_bad;
  assign reserved_mode_d = i_valid && mode_resv;

  // data outputs hold their last value between operations
  wire logic [31:0] mem_address_d;
  wire logic [31:0] wb_value_d;
  wire logic [4:0] wb_reg_idx_d;
  wire logic wb_side_b_d;
  assign mem_address_d = mem_req_d ? access_address : mem_address_q;
  assign wb_value_d = wb_en_d ? new_address : wb_value_q;
  // scaled ops write a destination chosen by decode; the base index stands in
  assign wb_reg_idx_d = wb_en_d ? i_base_reg_idx : wb_reg_idx_q;
  assign wb_side_b_d = wb_en_d ? i_unit_side_b : wb_side_b_q;

  // memory request pulses
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_req_q <= 1'h0;
      mem_write_q <= 1'h0;
    end else begin
      mem_req_q <= mem_req_d;
      mem_write_q <= mem_write_d;
    end
  end

  // write back pulse
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_en_q <= 1'h0;
    end else begin
      wb_en_q <= wb_en_d;
    end
  end

  // status pulses, one cycle after issue; done follows any issue, the error flags only their own case
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'h0;
      form_error_q <= 1'h0;
      reserved_mode_q <= 1'h0;
    end else begin
      done_q <= done_d;
      form_error_q <= form_error_d;
      reserved_mode_q <= reserved_mode_d;
    end
  end

  // memory address, moves only with a request
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_address_q <= RESET_WORD;
    end else begin
      mem_address_q <= mem_address_d;
    end
  end

  // write back value
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_value_q <= RESET_WORD;
    end else begin
      wb_value_q <= wb_value_d;
    end
  end

  // write back register number
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_reg_idx_q <= RESET_REG;
    end else begin
      wb_reg_idx_q <= wb_reg_idx_d;
    end
  end

  // write back register side
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_side_b_q <= 1'h0;
    end else begin
      wb_side_b_q <= wb_side_b_d;
    end
  end

  // ports follow the flops directly
  assign o_mem_req = mem_req_q;
  assign o_mem_write = mem_write_q;
  assign o_mem_address = mem_address_q;
  assign o_wb_en = wb_en_q;
  assign o_wb_side_b = wb_side_b_q;
  assign o_wb_reg_idx = wb_reg_idx_q;
  assign o_wb_value = wb_value_q;
  assign o_done = done_q;
  assign o_form_error = form_error_q;
  assign o_reserved_mode = reserved_mode_q;

endmodule

// file: circular_address_generator_assertions.sv
// concurrent checks on the address generator ports
module circular_address_generator_checker
  import addr_gen_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  input wire op_e i_op,
  input wire offset_src_e i_offset_src,
  input wire modify_e i_modify,
  input wire logic o_mem_req,
  input wire logic o_mem_write,
  input wire logic [31:0] o_mem_address,
  input wire logic o_wb_en,
  input wire logic o_done,
  input wire logic o_form_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire ldst = i_op == OP_LOAD || i_op == OP_STORE;
  wire scal = i_op == OP_SCALED_ADD || i_op == OP_SCALED_SUB;
  chk_done_one_cycle: assert property (i_valid |=> o_done) else $error("late done");
  chk_done_when_idle: assert property (!i_valid |=> !o_done) else $error("stray done");
  chk_error_is_silent: assert property (o_form_error |-> !o_mem_req && !o_wb_en)
    else $error("refused op acted");
  chk_other_no_access: assert property (i_valid && i_op == OP_OTHER |=> !o_mem_req && !o_wb_en)
    else $error("other op acted");
  chk_fifteen_no_mod: assert property (
    i_valid && ldst && i_offset_src == OFF_CONST_FIFTEEN && i_modify != MOD_NONE
    |=> o_form_error) else $error("long form modified");
  chk_store_writes: assert property (
    i_valid && i_op == OP_STORE && i_offset_src == OFF_INDEX |=> o_mem_req && o_mem_write)
    else $error("store not issued");
  chk_addr_holds: assert property (!o_mem_req |-> $stable(o_mem_address))
    else $error("address moved");
  chk_scaled_no_mem: assert property (i_valid && scal |=> !o_mem_req)
    else $error("scaled op accessed memory");
  cover property (o_form_error);
  cover property (o_mem_req && o_wb_en);
  cover property (o_mem_req && o_mem_write);
endmodule

bind circular_address_generator circular_address_generator_checker
  circular_address_generator_checker_i (.i_mclk, .i_rst_b, .i_valid, .i_op, .i_offset_src,
  .i_modify, .o_mem_req, .o_mem_write, .o_mem_address, .o_wb_en, .o_done, .o_form_error);

// file: reg_file_model.sv
// register file model: supplies base operands, takes write backs
module reg_file_model (
  input wire logic i_mclk,
  input wire logic i_wb_en,
  input wire logic i_wb_side_b,
  input wire logic [4:0] i_wb_reg_idx,
  input wire logic [31:0] i_wb_value,
  input wire logic i_side_b,
  input wire logic [4:0] i_reg_idx,
  output logic [31:0] o_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs_q [64];
  initial for (int k = 0; k < 64; k++) regs_q[k] = 32'(k) << 8;
  always @(posedge i_mclk) if (i_wb_en) regs_q[{i_wb_side_b, i_wb_reg_idx}] <= i_wb_value;
  assign o_value = regs_q[{i_side_b, i_reg_idx}];
endmodule

// file: test_circular_address_generator.sv
// random and corner-case bench for the address generator
module test_circular_address_generator;
  import addr_gen_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, valid, sub, sideb, mreq, mwr, wben, wbsb, done, ferr, rsv;
  op_e op;
  size_e size;
  offset_src_e osrc;
  modify_e modv;
  logic [4:0] idx, c5, wbidx;
  logic [14:0] c15;
  logic [31:0] base, idxop, address_mode_register, maddr, wbval;
  int seed = 32'hc20ac228;
  int miscompares;
  int checked;
  circular_address_generator circular_address_generator_i (.i_mclk(mclk), .i_rst_b(rst_b),
    .i_valid(valid), .i_op(op), .i_size(size), .i_subtract(sub), .i_offset_src(osrc),
    .i_modify(modv), .i_unit_side_b(sideb), .i_base_reg_idx(idx),
    .i_base_register_operand(base), .i_index_register_operand(idxop),
    .i_unsigned_const_five(c5), .i_unsigned_const_fifteen(c15), .i_address_mode_register(address_mode_register),
    .o_mem_req(mreq), .o_mem_write(mwr), .o_mem_address(maddr), .o_wb_en(wben),
    .o_wb_side_b(wbsb), .o_wb_reg_idx(wbidx), .o_wb_value(wbval), .o_done(done),
    .o_form_error(ferr), .o_reserved_mode(rsv));
  reg_file_model reg_file_model_i (.i_mclk(mclk), .i_wb_en(wben), .i_wb_side_b(wbsb),
    .i_wb_reg_idx(wbidx), .i_wb_value(wbval), .i_side_b(sideb), .i_reg_idx(idx), .o_value(base));
  function automatic int rnd(int n);
    return int'($unsigned($random(seed)) % n);
  endfunction
  // carry stops above bit n; n of 31 is plain linear
  function automatic logic [31:0] wrap(logic [31:0] b, o, logic s, logic [4:0] n);
    logic [31:0] m;
    m = n == 5'h1f ? '1 : (32'h2 << n) - 32'h1;
    return (b & ~m) | ((s ? b - o : b + o) & m);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic run(op_e o, size_e z, offset_src_e s, modify_e md, logic sb, logic [4:0] r,
                     logic [31:0] a);
    logic [31:0] b, off, nw;
    logic [1:0] mf;
    logic [4:0] n;
    logic ls, sc, circ, err;
    @(posedge mclk);
    valid <= 1'h1;
    {op, size, osrc, modv, sideb, idx, address_mode_register} <= {o, z, s, md, sb, r, a};
    {sub, idxop, c5, c15} <= {$random(seed), $random(seed)};
    #1;
    b = base;
    ls = o == OP_LOAD || o == OP_STORE;
    sc = o == OP_SCALED_ADD || o == OP_SCALED_SUB;
    mf = 2'(a >> {sb, r[1:0], 1'b0});
    circ = (ls || sc) && r >= 5'h4 && r <= 5'h7 && (mf == 2'h1 || mf == 2'h2);
    n = !circ ? 5'h1f : mf == 2'h1 ? a[20:16] : a[25:21];
    off = s == OFF_NONE ? 32'(md != MOD_NONE) : s == OFF_CONST_FIVE ? 32'(c5) :
          s == OFF_INDEX ? idxop : 32'(c15);
    off = off << z;
    err = ls ? s == OFF_CONST_FIFTEEN && (md != MOD_NONE || !sb || r < 5'he) :
          sc && (s == OFF_NONE || s == OFF_CONST_FIFTEEN);
    nw = wrap(b, off, sc ? o == OP_SCALED_SUB : sub, n);
    @(posedge mclk);
    valid <= 1'h0;
    #1;
    chk(ferr, err);
    chk(mreq, ls && !err);
    chk(mwr, o == OP_STORE && !err);
    if (ls && !err) chk(maddr, md == MOD_POST ? b : nw);
    chk(wben, !err && (sc || (ls && md != MOD_NONE)));
    if (wben === 1'h1) chk(wbval, nw);
    if (wben === 1'h1) chk({wbsb, wbidx}, {sb, r});
    if (!err) chk(rsv, (ls || sc) && r >= 5'h4 && r <= 5'h7 && mf == 2'h3);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    {rst_b, valid, sub, sideb, idx, c5, c15, idxop, address_mode_register} = '0;
    {op, size, osrc, modv} = {OP_OTHER, SIZE_BYTE, OFF_NONE, MOD_NONE};
    repeat (10) @(posedge mclk);
    rst_b <= 1'h1;
    run(OP_LOAD, SIZE_WORD, OFF_INDEX, MOD_POST, 1'h0, 5'h4, 32'h0004_0001);
    run(OP_SCALED_SUB, SIZE_HALF, OFF_CONST_FIVE, MOD_NONE, 1'h1, 5'h5, 32'h0060_0800);
    for (int k = 0; k < 4; k++) run(OP_STORE, size_e'(k), OFF_CONST_FIFTEEN, MOD_NONE, 1'h1,
      5'(14 + k % 2), 32'h0);
    repeat (400) run(op_e'(rnd(5)), size_e'(rnd(4)), offset_src_e'(rnd(4)), modify_e'(rnd(3)),
      1'(rnd(2)), 5'(rnd(16)), $random(seed));
    end_of_test;
  end
endmodule
